// *** verilog/csx_device.sv ***
`timescale 1ns/100ps
`default_nettype none
module csx_device
   import csx_pkg::*;
#(
   parameter int TIMEOUT_CYC = CSR_TIMEOUT_CYC
) (
   input wire logic ref_clk,
   input wire logic nrst,
   csx_link_if.dev link,
   // Register back end
   output logic regReq,
   output logic regWrite,
   output logic [CSR_ADDR_W-1:0] regAddr,
   output logic [DATA_W-1:0] regWdata,
   input wire logic regAck,
   input wire logic [DATA_W-1:0] regRdata,
   // Transceiver back end
   output logic xcvrReq,
   output logic xcvrWrite,
   output logic [CFG_ADDR_W-1:0] xcvrAddr,
   output logic [DATA_W-1:0] xcvrWdata,
   input wire logic xcvrAck,
   input wire logic [DATA_W-1:0] xcvrRdata
);
   // ------------------------------------------------------------
   // Control and status port
   // ------------------------------------------------------------
   csx_port_state_t csrState_q;
   logic csrLive;
   logic csrIsRead_q;
   logic csrExpired_q;
   logic regReq_q;
   logic regWrite_q;
   logic [CSR_ADDR_W-1:0] regAddr_q;
   logic [DATA_W-1:0] regWdata_q;
   logic [DATA_W-1:0] csrReadWord_q;
   logic timerExpired;
   logic csrStrobe;

   assign csrLive = csx_live(nrst, link.csrRstN);
   assign csrStrobe = link.csrRead || link.csrWrite;

   csx_read_timer #(
      .LIMIT(TIMEOUT_CYC)
   ) csx_read_timer_inst (
      .ref_clk(ref_clk),
      .nrst(csrLive),
      .run(csrState_q == PS_WAIT),
      .expired(timerExpired)
   );

   // Sequencing; a read wins if both strobes are raised together
   always_ff @(posedge ref_clk) begin
      if (!csrLive) begin
         csrState_q <= PS_IDLE;
      end else begin
         unique case (csrState_q)
            PS_IDLE: begin
               if (csrStrobe) begin
                  csrState_q <= PS_WAIT;
               end
            end
            PS_WAIT: begin
               // Latency is whatever the back end takes, cut off by the watchdog after TIMEOUT_CYC cycles
               if (regAck || timerExpired) begin
                  csrState_q <= PS_DONE;
               end
            end
            PS_DONE: begin
               csrState_q <= PS_IDLE;
            end
            default: begin
               csrState_q <= PS_IDLE;
            end
         endcase
      end
   end

   // Request capture towards the back end
   always_ff @(posedge ref_clk) begin
      if (!csrLive) begin
         regReq_q <= 1'b0;
         regWrite_q <= 1'b0;
         regAddr_q <= '0;
         regWdata_q <= RESET_WORD;
         csrIsRead_q <= 1'b0;
      end else if (csrState_q == PS_IDLE && csrStrobe) begin
         regReq_q <= 1'b1;
         regWrite_q <= !link.csrRead;
         regAddr_q <= link.csrAddress;
         regWdata_q <= link.csrWriteWord;
         csrIsRead_q <= link.csrRead;
      end else begin
         regReq_q <= 1'b0;
      end
   end

   // Answer capture; a late ack after expiry is dropped with the transfer
   always_ff @(posedge ref_clk) begin
      if (!csrLive) begin
         csrReadWord_q <= RESET_WORD;
         csrExpired_q <= 1'b0;
      end else if (csrState_q == PS_WAIT) begin
         if (regAck) begin
            csrReadWord_q <= csrIsRead_q ? regRdata : csrReadWord_q;
            csrExpired_q <= 1'b0;
         end else if (timerExpired) begin
            csrReadWord_q <= csrIsRead_q ? EXPIRED_WORD : csrReadWord_q;
            csrExpired_q <= csrIsRead_q;
         end
      end else if (csrState_q == PS_DONE) begin
         csrExpired_q <= 1'b0;
      end
   end

   assign regReq = regReq_q;
   assign regWrite = regWrite_q;
   assign regAddr = regAddr_q;
   assign regWdata = regWdata_q;

   // Stall from the first strobe cycle until the completion cycle
   assign link.csrStall = csrLive && ((csrState_q == PS_IDLE && csrStrobe)
                          || csrState_q == PS_WAIT);
   assign link.csrReadWordValid = (csrState_q == PS_DONE) && csrIsRead_q;
   assign link.csrReadExpired = (csrState_q == PS_DONE) && csrExpired_q;
   assign link.csrReadWord = csrReadWord_q;

   // ------------------------------------------------------------
   // Transceiver configuration port
   // ------------------------------------------------------------
   // Kept apart from the register back end so no address on the main
   // port can alias into transceiver space
   csx_port_state_t cfgState_q;
   logic cfgLive;
   logic cfgStrobe;
   logic xcvrReq_q;
   logic xcvrWrite_q;
   logic [CFG_ADDR_W-1:0] xcvrAddr_q;
   logic [DATA_W-1:0] xcvrWdata_q;
   logic [DATA_W-1:0] cfgReadWord_q;

   assign cfgLive = csx_live(nrst, link.cfgRstN);
   assign cfgStrobe = link.cfgRead || link.cfgWrite;

   // No watchdog here: a silent back end holds busy until reset
   always_ff @(posedge ref_clk) begin
      if (!cfgLive) begin
         cfgState_q <= PS_IDLE;
      end else begin
         unique case (cfgState_q)
            PS_IDLE: begin
               if (cfgStrobe) begin
                  cfgState_q <= PS_WAIT;
               end
            end
            PS_WAIT: begin
               if (xcvrAck) begin
                  cfgState_q <= PS_DONE;
               end
            end
            PS_DONE: begin
               cfgState_q <= PS_IDLE;
            end
            default: begin
               cfgState_q <= PS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!cfgLive) begin
         xcvrReq_q <= 1'b0;
         xcvrWrite_q <= 1'b0;
         xcvrAddr_q <= '0;
         xcvrWdata_q <= RESET_WORD;
      end else if (cfgState_q == PS_IDLE && cfgStrobe) begin
         xcvrReq_q <= 1'b1;
         xcvrWrite_q <= !link.cfgRead;
         xcvrAddr_q <= link.cfgAddress;
         xcvrWdata_q <= link.cfgWriteWord;
      end else begin
         xcvrReq_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!cfgLive) begin
         cfgReadWord_q <= RESET_WORD;
      end else if (cfgState_q == PS_WAIT && xcvrAck && !xcvrWrite_q) begin
         cfgReadWord_q <= xcvrRdata;
      end
   end

   assign xcvrReq = xcvrReq_q;
   assign xcvrWrite = xcvrWrite_q;
   assign xcvrAddr = xcvrAddr_q;
   assign xcvrWdata = xcvrWdata_q;

   // Busy falls in the completion cycle, which is when read data is good
   assign link.cfgBusy = cfgLive && ((cfgState_q == PS_IDLE && cfgStrobe)
                         || cfgState_q == PS_WAIT);
   assign link.cfgReadWord = cfgReadWord_q;
endmodule
`default_nettype wire

// *** verilog/csx_pkg.sv ***
`default_nettype none
package csx_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int CSR_ADDR_W = 16;
   localparam int CFG_ADDR_W = 12;
   localparam int DATA_W = 32;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   // Typical back-end read turnaround; only a reference figure
   localparam int CSR_TYPICAL_READ_CYC = 80;
   // Default read watchdog, overridable by TIMEOUT_CYC, well above any legal turnaround
   localparam int CSR_TIMEOUT_CYC = 1024;

   // ------------------------------------------------------------
   // Values after reset and on expiry
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] RESET_WORD = 32'h00000000;
   // Word returned when a read expires
   localparam logic [DATA_W-1:0] EXPIRED_WORD = 32'h00000000;

   // ------------------------------------------------------------
   // State encodings
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PS_IDLE = 3'b001,
      PS_WAIT = 3'b010,
      PS_DONE = 3'b100
   } csx_port_state_t;

   typedef enum logic [2:0] {
      HS_IDLE = 3'b001,
      HS_CSR = 3'b010,
      HS_CFG = 3'b100
   } csx_host_state_t;

   // A port runs only while both the global and its own reset are released
   function automatic logic csx_live(input logic globalRstN, input logic portRstN);
      return globalRstN & portRstN;
   endfunction
endpackage
`default_nettype wire

// *** verilog/csx_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface csx_link_if;
   import csx_pkg::*;
   // Control and status port
   logic csrRstN;
   logic [CSR_ADDR_W-1:0] csrAddress;
   logic csrRead;
   logic csrWrite;
   logic [DATA_W-1:0] csrWriteWord;
   logic [DATA_W-1:0] csrReadWord;
   logic csrReadWordValid;
   logic csrStall;
   logic csrReadExpired;
   // Transceiver configuration port
   logic cfgRstN;
   logic [CFG_ADDR_W-1:0] cfgAddress;
   logic cfgRead;
   logic cfgWrite;
   logic [DATA_W-1:0] cfgWriteWord;
   logic [DATA_W-1:0] cfgReadWord;
   logic cfgBusy;

   modport dev (
      input csrRstN, csrAddress, csrRead, csrWrite, csrWriteWord,
      output csrReadWord, csrReadWordValid, csrStall, csrReadExpired,
      input cfgRstN, cfgAddress, cfgRead, cfgWrite, cfgWriteWord,
      output cfgReadWord, cfgBusy
   );
   modport host (
      output csrRstN, csrAddress, csrRead, csrWrite, csrWriteWord,
      input csrReadWord, csrReadWordValid, csrStall, csrReadExpired,
      output cfgRstN, cfgAddress, cfgRead, cfgWrite, cfgWriteWord,
      input cfgReadWord, cfgBusy
   );
endinterface
`default_nettype wire

// *** verilog/csx_read_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module csx_read_timer
   import csx_pkg::*;
#(
   parameter int LIMIT = CSR_TIMEOUT_CYC
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic run,
   output logic expired
);
   localparam int CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

   logic [CW-1:0] count_q;

   // Restarts from zero whenever run drops, so each read gets a full window
   always_ff @(posedge ref_clk) begin
      if (!nrst || !run) begin
         count_q <= '0;
      end else if (count_q != LAST) begin
         count_q <= count_q + CW'(1);
      end
   end

   assign expired = run && (count_q == LAST);
endmodule
`default_nettype wire

// *** verilog/csx_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module csx_host
   import csx_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   csx_link_if.host link,
   // User command side
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic cmdToCfg,
   input wire logic cmdWrite,
   input wire logic [CSR_ADDR_W-1:0] cmdAddr,
   input wire logic [DATA_W-1:0] cmdWdata,
   output logic rspValid,
   output logic [DATA_W-1:0] rspData,
   output logic rspExpired,
   input wire logic csrResetReq,
   input wire logic cfgResetReq
);
   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   csx_host_state_t state_q;
   logic csrRstN_q;
   logic cfgRstN_q;
   logic csrRead_q;
   logic csrWrite_q;
   logic cfgRead_q;
   logic cfgWrite_q;
   logic [CSR_ADDR_W-1:0] csrAddress_q;
   logic [CFG_ADDR_W-1:0] cfgAddress_q;
   logic [DATA_W-1:0] csrWriteWord_q;
   logic [DATA_W-1:0] cfgWriteWord_q;
   logic rspValid_q;
   logic [DATA_W-1:0] rspData_q;
   logic rspExpired_q;
   logic take;
   logic csrDone;
   logic cfgDone;

   // One transfer at a time, so a second read cannot overlap
   assign cmdReady = (state_q == HS_IDLE) && nrst && !csrResetReq && !cfgResetReq;
   assign take = cmdValid && cmdReady;
   assign csrDone = (state_q == HS_CSR) && !link.csrStall && !csrResetReq;
   assign cfgDone = (state_q == HS_CFG) && !link.cfgBusy && !cfgResetReq;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         csrRstN_q <= 1'b0;
         cfgRstN_q <= 1'b0;
      end else begin
         csrRstN_q <= !csrResetReq;
         cfgRstN_q <= !cfgResetReq;
      end
   end

   // A port reset abandons that port's transfer with no answer
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_q <= HS_IDLE;
      end else begin
         unique case (state_q)
            HS_IDLE: begin
               if (take) begin
                  state_q <= cmdToCfg ? HS_CFG : HS_CSR;
               end
            end
            HS_CSR: begin
               if (csrDone || csrResetReq) begin
                  state_q <= HS_IDLE;
               end
            end
            HS_CFG: begin
               if (cfgDone || cfgResetReq) begin
                  state_q <= HS_IDLE;
               end
            end
            default: begin
               state_q <= HS_IDLE;
            end
         endcase
      end
   end

   // Request lines are held steady until the far end frees them
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         csrRead_q <= 1'b0;
         csrWrite_q <= 1'b0;
         csrAddress_q <= '0;
         csrWriteWord_q <= RESET_WORD;
      end else if (take && !cmdToCfg) begin
         csrRead_q <= !cmdWrite;
         csrWrite_q <= cmdWrite;
         csrAddress_q <= cmdAddr;
         csrWriteWord_q <= cmdWdata;
      end else if (csrDone || csrResetReq) begin
         csrRead_q <= 1'b0;
         csrWrite_q <= 1'b0;
      end
   end

   // Upper address bits are not carried on the narrower port
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cfgRead_q <= 1'b0;
         cfgWrite_q <= 1'b0;
         cfgAddress_q <= '0;
         cfgWriteWord_q <= RESET_WORD;
      end else if (take && cmdToCfg) begin
         cfgRead_q <= !cmdWrite;
         cfgWrite_q <= cmdWrite;
         cfgAddress_q <= cmdAddr[CFG_ADDR_W-1:0];
         cfgWriteWord_q <= cmdWdata;
      end else if (cfgDone || cfgResetReq) begin
         cfgRead_q <= 1'b0;
         cfgWrite_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Answer
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rspValid_q <= 1'b0;
         rspData_q <= RESET_WORD;
         rspExpired_q <= 1'b0;
      end else begin
         rspValid_q <= csrDone || cfgDone;
         if (csrDone && csrRead_q && link.csrReadWordValid) begin
            rspData_q <= link.csrReadWord;
         end else if (cfgDone && cfgRead_q) begin
            rspData_q <= link.cfgReadWord;
         end
         rspExpired_q <= csrDone && link.csrReadExpired;
      end
   end

   assign rspValid = rspValid_q;
   assign rspData = rspData_q;
   assign rspExpired = rspExpired_q;
   assign link.csrRstN = csrRstN_q;
   assign link.cfgRstN = cfgRstN_q;
   assign link.csrRead = csrRead_q;
   assign link.csrWrite = csrWrite_q;
   assign link.csrAddress = csrAddress_q;
   assign link.csrWriteWord = csrWriteWord_q;
   assign link.cfgRead = cfgRead_q;
   assign link.cfgWrite = cfgWrite_q;
   assign link.cfgAddress = cfgAddress_q;
   assign link.cfgWriteWord = cfgWriteWord_q;
endmodule
`default_nettype wire

// *** dv/csx_link_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module csx_link_sva
   import csx_pkg::*;
#(
   parameter int TIMEOUT_CYC = CSR_TIMEOUT_CYC
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic csrRstN,
   input wire logic csrRead,
   input wire logic csrWrite,
   input wire logic [DATA_W-1:0] csrReadWord,
   input wire logic csrReadWordValid,
   input wire logic csrStall,
   input wire logic csrReadExpired,
   input wire logic cfgRstN,
   input wire logic cfgRead,
   input wire logic cfgWrite,
   input wire logic cfgBusy
);
   // Watchdog plus the request and completion cycles around it
   localparam int MAX_STALL = TIMEOUT_CYC + 4;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst || !csrRstN);

   // ------------------------------------------------------------
   // Main port
   // ------------------------------------------------------------
   chk_valid_frees_port: assert property (csrReadWordValid |-> !csrStall)
      else $error("read-valid raised while stall high");
   chk_take_stalls: assert property ($rose(csrRead) |-> csrStall)
      else $error("new read not stalled");
   chk_idle_no_stall: assert property (!csrRead && !csrWrite |-> !csrStall)
      else $error("stall without request");
   chk_hold_request: assert property (csrStall |=> $stable(csrRead) && $stable(csrWrite))
      else $error("request changed while stalled");
   chk_read_done_valid: assert property (csrRead && $fell(csrStall) |-> csrReadWordValid)
      else $error("read finished without read-valid");
   chk_write_no_valid: assert property (csrWrite && !csrRead |-> !csrReadWordValid)
      else $error("read-valid during write");
   chk_valid_one_cycle: assert property (csrReadWordValid |=> !csrReadWordValid)
      else $error("read-valid longer than one cycle");
   chk_expired_word: assert property (csrReadExpired |-> csrReadWordValid
      && csrReadWord == EXPIRED_WORD)
      else $error("expired flag without completion");
   chk_stall_bounded: assert property (csrStall |-> ##[1:MAX_STALL] !csrStall)
      else $error("stall outlasts watchdog");
   chk_port_reset_idle: assert property (disable iff (!nrst)
      !csrRstN [*2] |-> !csrStall && !csrReadWordValid)
      else $error("main port not idle in reset");

   // ------------------------------------------------------------
   // Configuration port
   // ------------------------------------------------------------
   chk_cfg_take_busy: assert property (disable iff (!nrst || !cfgRstN)
      $rose(cfgRead || cfgWrite) |-> cfgBusy)
      else $error("config request not busy");
   chk_cfg_idle_free: assert property (disable iff (!nrst || !cfgRstN)
      !cfgRead && !cfgWrite |-> !cfgBusy)
      else $error("config busy without request");
   chk_cfg_reset_idle: assert property (disable iff (!nrst)
      !cfgRstN [*2] |-> !cfgBusy)
      else $error("config port busy in reset");

   cov_read_ok: cover property (csrReadWordValid && !csrReadExpired);
   cov_read_expired: cover property (csrReadExpired);
   cov_write_done: cover property (csrWrite && $fell(csrStall));
   cov_cfg_read: cover property (disable iff (!nrst) cfgRead && $fell(cfgBusy));
endmodule
`default_nettype wire

// *** dv/csr_and_xcvr_cfg_ports_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module csr_and_xcvr_cfg_ports_tb;
   import csx_pkg::*;
   // Short watchdog keeps the expiry scenarios fast
   localparam int TO = 100;
   logic ref_clk, nrst, regReq, regWrite, regAck, xcvrReq, xcvrWrite, xcvrAck;
   logic [CSR_ADDR_W-1:0] regAddr, cmdAddr, wrAddr, lastReg;
   logic [CFG_ADDR_W-1:0] xcvrAddr, lastCfg;
   logic [DATA_W-1:0] regWdata, regRdata, xcvrWdata, xcvrRdata, cmdWdata, rspData, wrData;
   logic cmdValid, cmdReady, cmdToCfg, cmdWrite, rspValid, rspExpired, csrResetReq, cfgResetReq;
   int fails, cmpCount, ackDelay, regWait, cfgWait, regReqs, xcvrReqs, base;
   int dl[3] = '{1, 5, 80};
   logic [15:0] ad[3] = '{16'h0004, 16'hfffc, 16'h8000};

   csx_link_if link();
   csx_device #(.TIMEOUT_CYC(TO)) csx_device_inst(.ref_clk(ref_clk), .nrst(nrst),
      .link(link), .regReq(regReq), .regWrite(regWrite), .regAddr(regAddr),
      .regWdata(regWdata), .regAck(regAck), .regRdata(regRdata), .xcvrReq(xcvrReq),
      .xcvrWrite(xcvrWrite), .xcvrAddr(xcvrAddr), .xcvrWdata(xcvrWdata),
      .xcvrAck(xcvrAck), .xcvrRdata(xcvrRdata));
   csx_host csx_host_inst(.ref_clk(ref_clk), .nrst(nrst), .link(link),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdToCfg(cmdToCfg),
      .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .rspValid(rspValid),
      .rspData(rspData), .rspExpired(rspExpired), .csrResetReq(csrResetReq),
      .cfgResetReq(cfgResetReq));
   csx_link_sva #(.TIMEOUT_CYC(TO)) csx_link_sva_inst(.ref_clk(ref_clk), .nrst(nrst),
      .csrRstN(link.csrRstN), .csrRead(link.csrRead), .csrWrite(link.csrWrite),
      .csrReadWord(link.csrReadWord), .csrReadWordValid(link.csrReadWordValid),
      .csrStall(link.csrStall), .csrReadExpired(link.csrReadExpired),
      .cfgRstN(link.cfgRstN), .cfgRead(link.cfgRead), .cfgWrite(link.cfgWrite),
      .cfgBusy(link.cfgBusy));

   always #5 ref_clk = ~ref_clk;

   function automatic logic [31:0] word_of(logic [15:0] a, logic cfg);
      return {cfg ? 16'hc0f9 : 16'h5e7a, a};
   endfunction

   // ------------------------------------------------------------
   // Back ends: answer after ackDelay cycles, never when it is 0
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      // Idle data lines toggle so a stale capture cannot pass
      regAck <= !regReq && regWait == 1;
      xcvrAck <= !xcvrReq && cfgWait == 1;
      regRdata <= (!regReq && regWait == 1) ? word_of(lastReg, 1'b0) : ~regRdata;
      xcvrRdata <= (!xcvrReq && cfgWait == 1) ? word_of({4'h0, lastCfg}, 1'b1) : ~xcvrRdata;
      if (regReq) begin
         regReqs++;
         regWait = ackDelay;
         lastReg = regAddr;
         if (regWrite) begin
            wrAddr = regAddr;
            wrData = regWdata;
         end
      end else if (regWait > 0) begin
         regWait--;
      end
      if (xcvrReq) begin
         xcvrReqs++;
         cfgWait = ackDelay;
         lastCfg = xcvrAddr;
         if (xcvrWrite) begin
            wrAddr = {4'h0, xcvrAddr};
            wrData = xcvrWdata;
         end
      end else if (cfgWait > 0) begin
         cfgWait--;
      end
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      if (fails == 0 && cmpCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic send_cmd(logic toCfg, logic wr, logic [15:0] a, logic [31:0] wd, int dly);
      ackDelay = dly;
      @(posedge ref_clk);
      cmdValid <= 1'b1;
      cmdToCfg <= toCfg;
      cmdWrite <= wr;
      cmdAddr <= a;
      cmdWdata <= wd;
      // Ready is looked at only where it has settled, away from the edge
      @(negedge ref_clk);
      for (int n = 0; cmdReady !== 1'b1; n++) begin
         if (n > 50) begin
            check("ready wait", 32'h0, 32'h1);
            complete_run();
         end
         @(negedge ref_clk);
      end
      @(posedge ref_clk);
      cmdValid <= 1'b0;
   endtask

   task automatic run_cmd(logic toCfg, logic wr, logic [15:0] a, logic [31:0] wd, int dly,
                          logic [31:0] expData, logic expExp);
      send_cmd(toCfg, wr, a, wd, dly);
      for (int n = 0; rspValid !== 1'b1; n++) begin
         if (n > 300) begin
            check("response wait", 32'h0, 32'h1);
            complete_run();
         end
         @(negedge ref_clk);
      end
      check("expired flag", 32'(rspExpired), 32'(expExp));
      if (!wr) begin
         check("read word", rspData, expData);
      end
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      nrst = 1'b0;
      regAck = 1'b0;
      xcvrAck = 1'b0;
      regRdata = 32'h0;
      xcvrRdata = 32'h0;
      {cmdValid, cmdToCfg, cmdWrite, csrResetReq, cfgResetReq} = 5'h0;
      cmdAddr = 16'h0;
      cmdWdata = 32'h0;
      {fails, cmpCount, ackDelay, regWait, cfgWait, regReqs, xcvrReqs} = '0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      run_cmd(1'b0, 1'b1, 16'h0010, 32'ha5a50001, 3, 32'h0, 1'b0);
      check("main write addr", 32'(wrAddr), 32'h00000010);
      check("main write data", wrData, 32'ha5a50001);
      foreach (dl[i]) begin
         run_cmd(1'b0, 1'b0, ad[i], 32'h0, dl[i], word_of(ad[i], 1'b0), 1'b0);
      end
      // Undecoded address: back end stays silent, watchdog must end it
      run_cmd(1'b0, 1'b0, 16'h0bad, 32'h0, 0, EXPIRED_WORD, 1'b1);
      run_cmd(1'b0, 1'b0, 16'h0020, 32'h0, 2, word_of(16'h0020, 1'b0), 1'b0);
      run_cmd(1'b0, 1'b1, 16'h0030, 32'h1234abcd, 0, 32'h0, 1'b0);
      run_cmd(1'b0, 1'b0, 16'h0040, 32'h0, 1, word_of(16'h0040, 1'b0), 1'b0);
      base = regReqs;
      run_cmd(1'b1, 1'b1, 16'h0123, 32'h0badf00d, 4, 32'h0, 1'b0);
      check("cfg write addr", 32'(wrAddr), 32'h00000123);
      check("cfg write data", wrData, 32'h0badf00d);
      run_cmd(1'b1, 1'b0, 16'h0456, 32'h0, 2, word_of(16'h0456, 1'b1), 1'b0);
      check("main requests during cfg", 32'(regReqs), 32'(base));
      check("cfg requests", 32'(xcvrReqs), 32'h00000002);
      // Config port has no watchdog: only a reset, global or its own port reset, frees it
      send_cmd(1'b1, 1'b0, 16'h0077, 32'h0, 0);
      repeat (10) @(negedge ref_clk);
      check("cfg busy hung", 32'(link.cfgBusy), 32'h1);
      @(posedge ref_clk);
      csrResetReq <= 1'b1;
      cfgResetReq <= 1'b1;
      repeat (3) @(posedge ref_clk);
      csrResetReq <= 1'b0;
      cfgResetReq <= 1'b0;
      @(negedge ref_clk);
      check("cfg busy after reset", 32'(link.cfgBusy), 32'h0);
      check("stall after reset", 32'(link.csrStall), 32'h0);
      run_cmd(1'b1, 1'b0, 16'h0abc, 32'h0, 1, word_of(16'h0abc, 1'b1), 1'b0);
      run_cmd(1'b0, 1'b0, 16'h0050, 32'h0, 6, word_of(16'h0050, 1'b0), 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
